// ### verilog/adfu_pkg.sv
package adfu_pkg;

  // ----------------------------------------------------------------
  // Descriptor layout
  // ----------------------------------------------------------------
  localparam int DESC_W       = 64;
  localparam int AF_POS       = 10;
  localparam int S1_AP2_POS   = 7;
  localparam int S2_AP1_POS   = 7;
  localparam int DBM_POS      = 51;
  localparam int ADDR_W       = 48;

  // ----------------------------------------------------------------
  // Capability levels
  // ----------------------------------------------------------------
  localparam logic [1:0] CAP_NONE   = 2'h0;
  localparam logic [1:0] CAP_ACCESS = 2'h1;
  localparam logic [1:0] CAP_DIRTY  = 2'h2;

  // ----------------------------------------------------------------
  // Outcome codes
  // ----------------------------------------------------------------
  localparam logic [1:0] RES_OK     = 2'h0;
  localparam logic [1:0] RES_ACCESS = 2'h1;
  localparam logic [1:0] RES_PERM   = 2'h2;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic              stage2;
    logic              is_write;
    logic              hw_access_update_enable;
    logic              dirty_update_enable;
    logic              access_fault_disable;
    logic [ADDR_W-1:0] addr;
    logic [DESC_W-1:0] desc;
  } adfu_req_t;

  typedef struct packed {
    logic [1:0]        fault;
    logic              cacheable;
    logic [DESC_W-1:0] desc;
  } adfu_rsp_t;

  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DESC_W-1:0] expect_val;
    logic [DESC_W-1:0] new_val;
  } adfu_cas_t;

endpackage : adfu_pkg

// ### verilog/adfu_desc_eval.sv
`timescale 1ns/1ps
module adfu_desc_eval
(
  // Descriptor and context
  input  wire adfu_pkg::adfu_req_t req,
  input  wire logic [1:0]          cap,
  // Decision
  output logic [1:0]               fault,
  output logic                     need_update,
  output logic [adfu_pkg::DESC_W-1:0] new_desc
);
  import adfu_pkg::*;

  logic af;
  logic writable;
  logic dirty_modifier_bit;
  logic ha_on;
  logic hd_on;

  always_comb
  begin
    af       = req.desc[AF_POS];
    dirty_modifier_bit      = req.desc[DBM_POS];
    writable = req.stage2 ? req.desc[S2_AP1_POS] : ~req.desc[S1_AP2_POS];
    ha_on    = (cap != CAP_NONE) && req.hw_access_update_enable;
    hd_on    = (cap == CAP_DIRTY) && ha_on && req.dirty_update_enable;
    fault    = RES_OK;
    new_desc = req.desc;
    need_update = 1'b0;
    if (!af && !ha_on && !req.access_fault_disable)
    begin
      fault = RES_ACCESS;
    end
    else if (req.is_write && !writable && !(hd_on && dirty_modifier_bit))
    begin
      // The accessed flag is left alone on a permission fault.
      fault = RES_PERM;
    end
    else
    begin
      if (!af && ha_on)
      begin
        new_desc[AF_POS] = 1'b1;
        need_update      = 1'b1;
      end
      if (req.is_write && !writable && hd_on && dirty_modifier_bit)
      begin
        if (req.stage2)
          new_desc[S2_AP1_POS] = 1'b1;
        else
          new_desc[S1_AP2_POS] = 1'b0;
        new_desc[AF_POS] = 1'b1;
        need_update      = 1'b1;
      end
    end
  end

endmodule : adfu_desc_eval

// ### verilog/adfu_flag_update.sv
`timescale 1ns/1ps
//
// Contract
// - Report none, accessed-only or accessed-and-dirty capability.
// - Per-stage enables decide update and scope.
// - Clear accessed flag with enable triggers atomic set.
// - Never clear the accessed flag.
// - Permission fault may leave accessed flag unset.
// - No update, flag clear, no disable: access fault.
// - Dirty update also writes accessed flag one.
// - Fault disable treats clear flag as set.
// - Access fault wins over permission fault.
// - Every flag update is atomic.
// - Never cache descriptors with accessed flag clear.
// - Dirty modifier bit sits at bit 51.
// - Dirty update makes read-only page writable atomically.
module adfu_flag_update
#(
  parameter logic [1:0] CAPABILITY = 2'h2
)
(
  // Clock and reset
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  // Capability report
  output logic [1:0]               flag_update_capability,
  // Descriptor fetch request
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire adfu_pkg::adfu_req_t req,
  // Result
  output logic                     rsp_valid,
  output adfu_pkg::adfu_rsp_t      rsp,
  // Atomic compare-and-swap to the table walk memory port
  output logic                     cas_valid,
  input  wire logic                cas_ready,
  output adfu_pkg::adfu_cas_t      cas,
  input  wire logic                cas_done,
  input  wire logic                cas_success
);
  import adfu_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_CAS  = 3'b010,
    ST_WAIT = 3'b100
  } adfu_state_t;

  adfu_state_t state_reg, state_next;
  adfu_cas_t   cas_reg, cas_next;
  adfu_rsp_t   rsp_reg, rsp_next;
  logic        rsp_valid_reg, rsp_valid_next;

  logic [1:0]        ev_fault;
  logic              ev_update;
  logic [DESC_W-1:0] ev_desc;

  assign flag_update_capability = CAPABILITY;

  adfu_desc_eval u_eval
  (
    .req         (req),
    .cap         (CAPABILITY),
    .fault       (ev_fault),
    .need_update (ev_update),
    .new_desc    (ev_desc)
  );

  // ----------------------------------------------------------------
  // Next state
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next     = state_reg;
    cas_next       = cas_reg;
    rsp_next       = rsp_reg;
    rsp_valid_next = 1'b0;
    unique case (state_reg)
      ST_IDLE:
      begin
        if (req_valid)
        begin
          if (ev_update)
          begin
            // One indivisible swap, so a racing software edit is never overwritten.
            cas_next.addr       = req.addr;
            cas_next.expect_val = req.desc;
            cas_next.new_val    = ev_desc | (req.desc & (64'h1 << AF_POS));
            state_next          = ST_CAS;
          end
          else
          begin
            rsp_next.fault     = ev_fault;
            rsp_next.desc      = req.desc;
            // A clear flag under fault disable is used as set but not cached.
            rsp_next.cacheable = (ev_fault == RES_OK) && req.desc[AF_POS];
            rsp_valid_next     = 1'b1;
          end
        end
      end
      ST_CAS:
      begin
        if (cas_ready)
          state_next = ST_WAIT;
      end
      ST_WAIT:
      begin
        if (cas_done)
        begin
          // A lost race returns the fetch unresolved; the walker refetches it.
          rsp_next.fault     = RES_OK;
          rsp_next.desc      = cas_reg.new_val;
          rsp_next.cacheable = cas_success;
          rsp_valid_next     = 1'b1;
          state_next         = ST_IDLE;
        end
      end
      default:
        state_next = ST_IDLE;
    endcase
  end

  always_ff @(posedge clk_sys or negedge resetn)
  begin
    if (!resetn)
    begin
      state_reg     <= ST_IDLE;
      cas_reg       <= '0;
      rsp_reg       <= '0;
      rsp_valid_reg <= 1'b0;
    end
    else
    begin
      state_reg     <= state_next;
      cas_reg       <= cas_next;
      rsp_reg       <= rsp_next;
      rsp_valid_reg <= rsp_valid_next;
    end
  end

  assign req_ready = (state_reg == ST_IDLE);
  assign cas_valid = (state_reg == ST_CAS);
  assign cas       = cas_reg;
  assign rsp       = rsp_reg;
  assign rsp_valid = rsp_valid_reg;

endmodule : adfu_flag_update

// ### verification/adfu_mem_model.sv
`timescale 1ns/1ps
module adfu_mem_model
(
  // Clock, reset and pacing
  input  wire logic                clk_sys,
  input  wire logic                resetn,
  input  wire logic [1:0]          lag,
  // Compare-and-swap port
  input  wire logic                cas_valid,
  input  wire adfu_pkg::adfu_cas_t cas,
  output logic                     cas_ready,
  output logic                     cas_done,
  output logic                     cas_success
);
  import adfu_pkg::*;
  logic [DESC_W-1:0] mem;
  logic [1:0]        cnt;
  logic              busy;
  logic              hit;
  // Success toggles between answers, so a stale sample cannot pass.
  always @(posedge clk_sys or negedge resetn)
    if (!resetn)
      {cnt, busy, hit, cas_ready, cas_done, cas_success} <= '0;
    else
    begin
      cas_ready <= 1'b0;
      cas_done <= 1'b0;
      cas_success <= ~cas_success;
      cnt <= (busy || cas_valid) ? cnt + 2'h1 : 2'h0;
      if (cas_ready)
      begin
        hit <= mem === cas.expect_val;
        if (mem === cas.expect_val)
          mem <= cas.new_val;
        busy <= 1'b1;
        cnt <= 2'h0;
      end
      else if (busy && cnt == lag)
        {cas_done, cas_success, busy} <= {1'b1, hit, 1'b0};
      else if (cas_valid && !busy && cnt >= lag)
        cas_ready <= 1'b1;
    end
endmodule : adfu_mem_model

// ### verification/adfu_flag_update_chk.sv
`timescale 1ns/1ps
module adfu_flag_update_chk
#(parameter logic [1:0] CAPABILITY = 2'h2)
(
  // Watched ports
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [1:0] flag_update_capability,
  input wire logic req_valid,
  input wire logic req_ready,
  input wire adfu_pkg::adfu_req_t req,
  input wire logic rsp_valid,
  input wire adfu_pkg::adfu_rsp_t rsp,
  input wire logic cas_valid,
  input wire logic cas_ready,
  input wire adfu_pkg::adfu_cas_t cas,
  input wire logic cas_done,
  input wire logic cas_success
);
  import adfu_pkg::*;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (!resetn);
  wire ha = req.hw_access_update_enable && CAPABILITY != CAP_NONE;
  wire af = req.desc[AF_POS];
  wire ro = req.stage2 ? !req.desc[S2_AP1_POS] : req.desc[S1_AP2_POS];
  sequence s_take;
    req_valid && req_ready;
  endsequence
  a_cap_level: assert property (
    flag_update_capability == CAPABILITY) else $error("capability wrong");
  a_af_set: assert property (
    s_take ##0 (!af && ha && !req.is_write) |=> cas_valid && cas.new_val[AF_POS]
    && cas.addr == $past(req.addr)) else $error("flag set missing");
  a_dirty_set: assert property (
    s_take ##0 (af && ro && req.is_write && req.desc[DBM_POS] && ha && req.dirty_update_enable
    && CAPABILITY == CAP_DIRTY) |=> cas_valid && cas.new_val[7] == $past(req.stage2))
    else $error("dirty update missing");
  a_access_fault: assert property (
    s_take ##0 (!af && !req.access_fault_disable && !ha) |=> rsp_valid
    && rsp.fault == RES_ACCESS) else $error("access fault missing");
  a_perm_fault: assert property (
    s_take ##0 (af && ro && req.is_write && !req.desc[DBM_POS]) |=> rsp_valid
    && rsp.fault == RES_PERM) else $error("permission fault missing");
  a_af_kept: assert property (
    cas_valid |-> cas.new_val[AF_POS] && cas.new_val[DBM_POS] == cas.expect_val[DBM_POS])
    else $error("swap value wrong");
  a_cas_held: assert property (
    cas_valid && !cas_ready |=> cas_valid && $stable(cas)) else $error("swap dropped");
  a_done_rsp: assert property (
    cas_done && !req_ready && !cas_valid |=> rsp_valid && !req_ready == 1'b0
    && rsp.cacheable == $past(cas_success)) else $error("swap answer wrong");
  a_no_cache: assert property (
    rsp_valid && rsp.cacheable |-> rsp.desc[AF_POS]) else $error("clear flag cached");
endmodule : adfu_flag_update_chk
bind adfu_flag_update adfu_flag_update_chk #(.CAPABILITY(CAPABILITY)) chk (.*);

// ### verification/adfu_flag_update_tb.sv
`timescale 1ns/1ps
module adfu_flag_update_tb;
  import adfu_pkg::*;
  logic clk_sys, resetn, req_valid, req_ready, rsp_valid, cas_valid;
  logic cas_ready, cas_done, cas_success;
  logic [1:0] flag_update_capability, lag;
  adfu_req_t req;
  adfu_rsp_t rsp;
  adfu_cas_t cas;
  logic [131:0] q[$];
  logic [131:0] e;
  int fails = 0, total_checks = 0, cyc = 0;
  adfu_flag_update uut (.*);
  adfu_mem_model mm (.*);
  initial
  begin
    clk_sys = 0;
    forever #12.5 clk_sys = ~clk_sys;
  end
  task check(input logic [63:0] seen, input logic [63:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value at %0t: saw %h, expected %h", $time, seen, exp);
    end
  endtask : check
  task conclude;
    $display("checks %0d, mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : conclude
  // Expectations come from the flag rules and the preset memory; the far side may refuse a swap.
  task go;
    logic [63:0] d, n;
    logic st, wr, ha, hd, fd, ro, dirty, upd, ok;
    logic [1:0] f;
    d = {$urandom, $urandom};
    {st, wr, ha, hd, fd} = 5'($urandom);
    ok = ($urandom % 8) != 0;
    ro = st ? !d[S2_AP1_POS] : d[S1_AP2_POS];
    dirty = wr && ro && d[DBM_POS] && hd && ha;
    f = (!d[AF_POS] && !fd && !ha) ? RES_ACCESS : (wr && ro && !dirty) ? RES_PERM : RES_OK;
    upd = f == RES_OK && ((!d[AF_POS] && ha) || dirty);
    n = d;
    n[AF_POS] = 1'b1;
    if (dirty)
      n[S1_AP2_POS] = st;
    while (req_ready !== 1'b1)
      @(negedge clk_sys);
    mm.mem <= ok ? d : ~d;
    lag <= 2'($urandom);
    req_valid <= 1'b1;
    req <= '{st, wr, ha, hd, fd, ADDR_W'({$urandom, $urandom}), d};
    q.push_back({upd, f, upd ? ok : d[AF_POS], ok ? n : ~d, upd ? n : d});
    @(negedge clk_sys);
    if (req_ready !== 1'b1)
      req_valid <= 1'b0;
  endtask : go
  always @(negedge clk_sys)
    if (rsp_valid === 1'b1)
    begin
      e = q.pop_front();
      check(rsp.fault, e[130:129]);
      check(rsp.desc, e[63:0]);
      if (e[130:129] == RES_OK)
        check(rsp.cacheable, e[128]);
      if (e[131])
        check(mm.mem, e[127:64]);
    end
  always @(posedge clk_sys)
  begin
    cyc++;
    if (cyc > 6000)
    begin
      fails++;
      conclude;
    end
  end
  initial
  begin
    {resetn, req_valid, lag} = '0;
    req = '0;
    void'($urandom(40453));
    repeat (6) @(posedge clk_sys);
    @(negedge clk_sys) resetn = 1'b1;
    check(flag_update_capability, CAP_DIRTY);
    $display("capability test done");
    repeat (300) go;
    if (req_ready === 1'b1)
      req_valid <= 1'b0;
    repeat (20) @(negedge clk_sys);
    check(q.size(), 0);
    $display("descriptor fetch test done");
    conclude;
  end
endmodule : adfu_flag_update_tb
